// ==== shared/io_space_pkg.sv ====
// Purpose: Shared constants and carriers for the I/O space decode block.
// Assumes: Byte-wide data space addressed by the CPU core, APB word registers.
// Notes: Register offsets below the extended region follow the legacy map.
package io_space_pkg;
  localparam logic [7:0] SHORT_IO_BASE = 8'h20;
  localparam logic [7:0] SHORT_IO_LAST = 8'h5f;
  localparam logic [7:0] EXT_BASE = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hff;
  localparam logic [5:0] SHORT_IO_SPAN = 6'h3f;
  localparam logic [7:0] PCMASK0_ADDR = 8'h6b;
  localparam logic [7:0] PCMASK1_ADDR = 8'h6c;
  localparam logic [7:0] TMR3_LO_ADDR = 8'h80;
  localparam logic [7:0] TMR3_HI_ADDR = 8'h8b;
  localparam logic [7:0] TMR3_IRQ_LO_ADDR = 8'h7c;
  localparam logic [7:0] TMR3_IRQ_HI_ADDR = 8'h7d;
  localparam logic [7:0] SERIAL0_BAUD_HIGH_ADDR = 8'h40;
  localparam logic [7:0] SERIAL1_BAUD_HIGH_ADDR = 8'h5c;
  localparam logic [7:0] PORTS_FIRST_ADDR = 8'h26;
  localparam logic [7:0] PORTS_LAST_ADDR = 8'h3b;
  localparam logic [11:0] APB_CTRL_OFS = 12'h000;
  localparam logic [11:0] APB_PORTS_OFS = 12'h004;
  localparam logic [11:0] APB_PULL_OFS = 12'h008;
  localparam logic [11:0] APB_STATUS_OFS = 12'h00c;
  localparam logic [11:0] APB_PORTE_OFS = 12'h010;
  localparam int CTRL_JTAG_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int VEC_COUNT_FULL = 28;
  localparam int VEC_COUNT_LEGACY = 21;
  localparam int PORT_WIDE = 8;
  localparam int PORT_NARROW = 3;
  localparam int PORT_PINS = 4 * PORT_WIDE + PORT_NARROW;
  localparam int TDI_PIN = 2 * PORT_WIDE + 7;
  localparam int TMS_PIN = 2 * PORT_WIDE + 5;
  localparam int TCK_PIN = 2 * PORT_WIDE + 4;

  typedef enum logic [1:0] {TGT_RAM, TGT_IO, TGT_NONE} target_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic ioInstr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_s;

  typedef struct packed {
    logic extRegSel;
    logic shortIoSel;
    logic ramSel;
    logic pcIntSel;
    logic timer3Sel;
  } decode_s;

  typedef struct packed {
    logic extVectors;
    logic wdtTimedUnlock;
    logic rxDoubleBuffer;
    logic pinChangeIrq;
    logic timer3Access;
  } feature_s;
endpackage

// ==== core/io_addr_decode.sv ====
// Purpose: Combinational data-space decode for one CPU access.
// Assumes: The request is stable for the cycle in which it is presented.
// Notes: Short I/O addresses are 0x00..0x3f on the I/O instructions.
`timescale 1ns/100ps
`default_nettype none
module io_addr_decode
  import io_space_pkg::*;
(
  input wire cpu_req_s req,
  input wire logic legacyMode,
  output decode_s dec
);
  function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  wire logic [7:0] dataAddr;
  wire logic extHit;
  // I/O instructions carry a 6-bit index that maps onto data address 0x20 upward.
  assign dataAddr = req.ioInstr ? (SHORT_IO_BASE + {2'h0, req.addr[5:0] & SHORT_IO_SPAN}) : req.addr;
  assign extHit = !req.ioInstr && inRange(req.addr, EXT_BASE, EXT_LAST);
  assign dec.shortIoSel = req.valid && inRange(dataAddr, SHORT_IO_BASE, SHORT_IO_LAST);
  assign dec.extRegSel = req.valid && extHit && !legacyMode;
  assign dec.ramSel = req.valid && !req.ioInstr && (extHit ? legacyMode : !inRange(req.addr, 8'h00, SHORT_IO_LAST));
  assign dec.pcIntSel = dec.extRegSel && inRange(req.addr, PCMASK0_ADDR, PCMASK1_ADDR);
  assign dec.timer3Sel = dec.extRegSel && (inRange(req.addr, TMR3_LO_ADDR, TMR3_HI_ADDR)
                         || inRange(req.addr, TMR3_IRQ_LO_ADDR, TMR3_IRQ_HI_ADDR));
endmodule
`default_nettype wire

// ==== core/io_port_pads.sv ====
// Purpose: Pad control for the general-purpose port pins.
// Assumes: Reset is the combined asynchronous reset condition.
// Notes: Output enable is active low, as for a pad driver.
`timescale 1ns/100ps
`default_nettype none
module io_port_pads
  import io_space_pkg::*;
(
  input wire logic reset,
  input wire logic jtagEnable,
  input wire logic [PORT_PINS-1:0] outVal,
  input wire logic [PORT_PINS-1:0] dirOut,
  input wire logic [PORT_PINS-1:0] pullSel,
  output logic [PORT_PINS-1:0] padOut,
  output logic [PORT_PINS-1:0] padOeN,
  output logic [PORT_PINS-1:0] padPullUp
);
  wire logic [PORT_PINS-1:0] jtagPulls;
  assign jtagPulls = jtagEnable ? ((PORT_PINS'(1) << TDI_PIN) | (PORT_PINS'(1) << TMS_PIN)
                     | (PORT_PINS'(1) << TCK_PIN)) : '0;
  // Gated straight from reset so pins float even with no clock running.
  assign padOeN = reset ? '1 : ~dirOut;
  assign padOut = reset ? '0 : outVal;
  assign padPullUp = (reset ? '0 : (pullSel & ~dirOut)) | jtagPulls;
endmodule
`default_nettype wire

// ==== core/io_space_compat.sv ====
// Purpose: Extended I/O decode, legacy-compatibility feature control and port pins.
// Assumes: CPU requests are synchronous to mclk; APB master follows the usual protocol.
// Notes: The fuse is caught by a clocked process after reset release.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Extended register region spans data addresses 0x60 through 0xff over RAM.
// - Extended registers answer only data loads and stores, never I/O instructions.
// - Legacy registers keep their addresses in the 64-location short I/O space.
// - With the fuse programmed, 0x60..0xff becomes plain RAM.
// - Legacy mode removes the extra interrupt vectors.
// - Legacy mode disables the watchdog timed unlock sequence.
// - Legacy mode turns off receive double buffering.
// - Legacy mode makes pin change interrupts unavailable.
// - Legacy mode leaves only the first 16-bit timer reachable.
// - Both serial baud high registers keep fixed separate addresses in either mode.
// - Port pins float as soon as reset is active, clock or not.
// - With the test port enabled, pulls on its three pins stay on in reset.
// - A long enough low external reset pulse resets without a clock.
// - Four 8-bit and one 3-bit ports with per-pin pull-ups; pins 16..34 bidirectional, pins 0..15 input only.
module io_space_compat
  import io_space_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic extResetN,
  input wire logic legacyCompatFuse,
  input wire cpu_req_s cpuReq,
  output decode_s cpuDecode,
  output target_e cpuTarget,
  output feature_s features,
  output logic [4:0] vectorCount,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PORT_PINS-1:0] padOut,
  output logic [PORT_PINS-1:0] padOeN,
  output logic [PORT_PINS-1:0] padPullUp
);
  typedef enum logic [1:0] {ST_RESET, ST_STRAP, ST_RUN} boot_e;

  wire logic sysReset;
  logic fuseCaught_r;
  logic legacy_r;
  boot_e boot_r;
  boot_e boot_nxt;
  logic [31:0] ctrl_r;
  logic [PORT_PINS-1:0] dir_r;
  logic [PORT_PINS-1:0] val_r;
  logic [PORT_PINS-1:0] pull_r;
  logic [31:0] accessCount_r;
  wire logic apbAccess;
  wire logic apbWrite;
  wire logic apbKnown;
  wire logic [31:0] readMux;
  wire logic [PORT_PINS-1:0] mergedDir;
  wire logic [PORT_PINS-1:0] mergedVal;

  // The pin is combined asynchronously so a long low pulse resets without mclk.
  assign sysReset = reset | !extResetN;

  assign boot_nxt = (boot_r == ST_RESET) ? ST_STRAP : ST_RUN;

  always_ff @(posedge mclk or posedge sysReset) begin
    if (sysReset) begin
      boot_r <= ST_RESET;
      fuseCaught_r <= 1'b0;
    end else begin
      boot_r <= boot_nxt;
      if (boot_r == ST_RESET) begin
        fuseCaught_r <= 1'b1;
      end
    end
  end

  // The fuse is sampled once after release; changing it later has no effect.
  always_ff @(posedge mclk or posedge sysReset) begin
    if (sysReset) begin
      legacy_r <= 1'b0;
    end else if (boot_r == ST_RESET) begin
      legacy_r <= legacyCompatFuse;
    end
  end

  io_addr_decode u_decode (
    .req(cpuReq),
    .legacyMode(legacy_r),
    .dec(cpuDecode)
  );

  assign cpuTarget = cpuDecode.ramSel ? TGT_RAM :
                     (cpuDecode.extRegSel || cpuDecode.shortIoSel) ? TGT_IO : TGT_NONE;

  assign features.extVectors = !legacy_r;
  assign features.wdtTimedUnlock = !legacy_r;
  assign features.rxDoubleBuffer = !legacy_r;
  assign features.pinChangeIrq = !legacy_r;
  assign features.timer3Access = !legacy_r;
  assign vectorCount = legacy_r ? 5'(VEC_COUNT_LEGACY) : 5'(VEC_COUNT_FULL);

  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign apbKnown = (paddr == APB_CTRL_OFS) || (paddr == APB_PORTS_OFS) || (paddr == APB_PULL_OFS)
                    || (paddr == APB_STATUS_OFS) || (paddr == APB_PORTE_OFS);
  assign pready = 1'b1;
  assign pslverr = apbAccess && !apbKnown;

  assign readMux = (paddr == APB_CTRL_OFS) ? ctrl_r :
                   (paddr == APB_PORTS_OFS) ? {val_r[31:16], dir_r[31:16]} :
                   (paddr == APB_PULL_OFS) ? pull_r[31:0] :
                   (paddr == APB_STATUS_OFS) ? {25'h0, vectorCount, fuseCaught_r, legacy_r} :
                   (paddr == APB_PORTE_OFS) ? {8'h0, 5'h0, pull_r[PORT_PINS-1:32],
                                               5'h0, val_r[PORT_PINS-1:32], 5'h0, dir_r[PORT_PINS-1:32]} :
                   32'h00000000;

  // Port words: low 16 bits of the ports register carry pins 16..31 direction.
  assign mergedDir = (apbWrite && paddr == APB_PORTS_OFS) ? {dir_r[PORT_PINS-1:32], pwdata[15:0], dir_r[15:0]} :
                     (apbWrite && paddr == APB_PORTE_OFS) ? {pwdata[2:0], dir_r[31:0]} : dir_r;
  assign mergedVal = (apbWrite && paddr == APB_PORTS_OFS) ? {val_r[PORT_PINS-1:32], pwdata[31:16], val_r[15:0]} :
                     (apbWrite && paddr == APB_PORTE_OFS) ? {pwdata[10:8], val_r[31:0]} : val_r;

  always_ff @(posedge mclk or posedge sysReset) begin
    if (sysReset) begin
      prdata <= 32'h00000000;
      ctrl_r <= CTRL_RESET;
      dir_r <= '0;
      val_r <= '0;
      pull_r <= '0;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? readMux : prdata;
      dir_r <= mergedDir;
      val_r <= mergedVal;
      if (apbWrite && paddr == APB_CTRL_OFS) begin
        ctrl_r <= {31'h0, pwdata[CTRL_JTAG_BIT]};
      end
      if (apbWrite && paddr == APB_PULL_OFS) begin
        pull_r <= {pull_r[PORT_PINS-1:32], pwdata};
      end else if (apbWrite && paddr == APB_PORTE_OFS) begin
        pull_r <= {pwdata[18:16], pull_r[31:0]};
      end
    end
  end

  always_ff @(posedge mclk or posedge sysReset) begin
    if (sysReset) begin
      accessCount_r <= 32'h00000000;
    end else if (cpuDecode.extRegSel) begin
      accessCount_r <= accessCount_r + 32'h00000001;
    end
  end

  io_port_pads u_pads (
    .reset(sysReset),
    .jtagEnable(ctrl_r[CTRL_JTAG_BIT]),
    .outVal(val_r),
    .dirOut(dir_r),
    .pullSel(pull_r),
    .padOut(padOut),
    .padOeN(padOeN),
    .padPullUp(padPullUp)
  );

  property p_ext_blocked_io;
    @(posedge mclk) disable iff (sysReset) (cpuReq.valid && cpuReq.ioInstr) |-> !cpuDecode.extRegSel;
  endproperty
  a_ext_blocked_io: assert property (p_ext_blocked_io) else $error("I/O instruction reached extended region");

  property p_legacy_ram;
    @(posedge mclk) disable iff (sysReset)
      (legacy_r && cpuReq.valid && !cpuReq.ioInstr && cpuReq.addr >= EXT_BASE) |-> (cpuTarget == TGT_RAM);
  endproperty
  a_legacy_ram: assert property (p_legacy_ram) else $error("Legacy mode did not map extended region to RAM");

  property p_ext_decode;
    @(posedge mclk) disable iff (sysReset)
      (!legacy_r && cpuReq.valid && !cpuReq.ioInstr && cpuReq.addr >= EXT_BASE) |-> cpuDecode.extRegSel;
  endproperty
  a_ext_decode: assert property (p_ext_decode) else $error("Extended region not decoded");

  property p_vectors;
    @(posedge mclk) disable iff (sysReset) legacy_r |-> (vectorCount == 5'(VEC_COUNT_LEGACY)) && !features.extVectors;
  endproperty
  a_vectors: assert property (p_vectors) else $error("Extended vectors present in legacy mode");

  property p_wdt;
    @(posedge mclk) disable iff (sysReset) features.wdtTimedUnlock != legacy_r;
  endproperty
  a_wdt: assert property (p_wdt) else $error("Watchdog unlock not tied to mode");

  property p_rx;
    @(posedge mclk) disable iff (sysReset) legacy_r |-> !features.rxDoubleBuffer && !features.pinChangeIrq;
  endproperty
  a_rx: assert property (p_rx) else $error("Receive buffering or pin change active in legacy mode");

  property p_pcint;
    @(posedge mclk) disable iff (sysReset) legacy_r |-> !cpuDecode.pcIntSel && !cpuDecode.timer3Sel;
  endproperty
  a_pcint: assert property (p_pcint) else $error("Extended peripheral selected in legacy mode");

  property p_baud;
    @(posedge mclk) disable iff (sysReset)
      (cpuReq.valid && !cpuReq.ioInstr && (cpuReq.addr == SERIAL0_BAUD_HIGH_ADDR
       || cpuReq.addr == SERIAL1_BAUD_HIGH_ADDR)) |-> cpuDecode.shortIoSel && cpuTarget == TGT_IO;
  endproperty
  a_baud: assert property (p_baud) else $error("Baud high register moved");

  property p_float;
    @(posedge mclk) disable iff (sysReset) $rose(boot_r == ST_STRAP) |-> $past(padOeN) == '1;
  endproperty
  a_float: assert property (p_float) else $error("Pins driven during reset");

  property p_jtag_pull;
    @(posedge mclk) disable iff (sysReset) ctrl_r[CTRL_JTAG_BIT] |-> padPullUp[TDI_PIN] && padPullUp[TMS_PIN]
      && padPullUp[TCK_PIN];
  endproperty
  a_jtag_pull: assert property (p_jtag_pull) else $error("Test port pull-ups missing");

  // These two carry no disable, because the pins must be right while reset is active.
  property p_float_in_reset;
    @(posedge mclk) sysReset |-> (padOeN == '1) && (padOut == '0);
  endproperty
  a_float_in_reset: assert property (p_float_in_reset) else $error("Pins driven while reset is active");

  property p_jtag_pull_reset;
    @(posedge mclk) (sysReset && ctrl_r[CTRL_JTAG_BIT])
      |-> padPullUp[TDI_PIN] && padPullUp[TMS_PIN] && padPullUp[TCK_PIN];
  endproperty
  a_jtag_pull_reset: assert property (p_jtag_pull_reset) else $error("Test port pull-ups lost in reset");

  property p_short_io;
    @(posedge mclk) disable iff (sysReset)
      (cpuReq.valid && cpuReq.ioInstr) |-> cpuDecode.shortIoSel && !cpuDecode.ramSel && (cpuTarget == TGT_IO);
  endproperty
  a_short_io: assert property (p_short_io) else $error("I/O instruction left the short I/O space");

  property p_port_regs;
    @(posedge mclk) disable iff (sysReset)
      (cpuReq.valid && !cpuReq.ioInstr && cpuReq.addr >= PORTS_FIRST_ADDR && cpuReq.addr <= PORTS_LAST_ADDR)
      |-> cpuDecode.shortIoSel;
  endproperty
  a_port_regs: assert property (p_port_regs) else $error("Port registers left the short I/O space");

  property p_timer3_decode;
    @(posedge mclk) disable iff (sysReset)
      (!legacy_r && cpuReq.valid && !cpuReq.ioInstr && cpuReq.addr >= TMR3_LO_ADDR
       && cpuReq.addr <= TMR3_HI_ADDR) |-> cpuDecode.timer3Sel;
  endproperty
  a_timer3_decode: assert property (p_timer3_decode) else $error("Second timer not decoded");

  property p_pcint_decode;
    @(posedge mclk) disable iff (sysReset)
      (!legacy_r && cpuReq.valid && !cpuReq.ioInstr
       && (cpuReq.addr == PCMASK0_ADDR || cpuReq.addr == PCMASK1_ADDR)) |-> cpuDecode.pcIntSel;
  endproperty
  a_pcint_decode: assert property (p_pcint_decode) else $error("Pin change masks not decoded");

  property p_io_no_periph;
    @(posedge mclk) disable iff (sysReset)
      (cpuReq.valid && cpuReq.ioInstr) |-> !cpuDecode.pcIntSel && !cpuDecode.timer3Sel;
  endproperty
  a_io_no_periph: assert property (p_io_no_periph) else $error("I/O instruction selected an extended unit");

  property p_features_full;
    @(posedge mclk) disable iff (sysReset) !legacy_r |-> (features == '1) && (vectorCount == 5'(VEC_COUNT_FULL));
  endproperty
  a_features_full: assert property (p_features_full) else $error("Feature missing in full mode");

  property p_timer3_legacy;
    @(posedge mclk) disable iff (sysReset) legacy_r |-> !features.timer3Access && !features.wdtTimedUnlock;
  endproperty
  a_timer3_legacy: assert property (p_timer3_legacy) else $error("Second timer reachable in legacy mode");

  property p_fuse_capture;
    @(posedge mclk) disable iff (sysReset) $rose(fuseCaught_r) |-> legacy_r == $past(legacyCompatFuse);
  endproperty
  a_fuse_capture: assert property (p_fuse_capture) else $error("Fuse level not captured");

  property p_fuse_hold;
    @(posedge mclk) disable iff (sysReset) (boot_r == ST_RUN) |=> $stable(legacy_r);
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("Mode changed while running");

  property p_ext_count;
    @(posedge mclk) disable iff (sysReset) (cpuReq.valid && (cpuReq.ioInstr || legacy_r)) |=> $stable(accessCount_r);
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("Extended region counted a blocked access");

  property p_pad_drive;
    @(posedge mclk) disable iff (sysReset) (padOeN == ~dir_r) && (padOut == val_r);
  endproperty
  a_pad_drive: assert property (p_pad_drive) else $error("Pads do not follow direction and value");

  property p_ctrl_write;
    @(posedge mclk) disable iff (sysReset)
      (apbWrite && paddr == APB_CTRL_OFS) |=> ctrl_r[CTRL_JTAG_BIT] == $past(pwdata[CTRL_JTAG_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("Test port enable write lost");

  property p_porte_pull;
    @(posedge mclk) disable iff (sysReset)
      (apbWrite && paddr == APB_PORTE_OFS) |=> pull_r[PORT_PINS-1:32] == $past(pwdata[18:16]);
  endproperty
  a_porte_pull: assert property (p_porte_pull) else $error("Narrow port pull write lost");
endmodule
`default_nettype wire

// ==== test/cpu_core_model.sv ====
// Purpose: Behavioural CPU core that presents one data-space access at a time.
// Assumes: The bench asks for an access by holding issue high for one cycle.
// Notes: Released fields turn to the inverse of their last value, so nothing stale looks valid.
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model
  import io_space_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic issue,
  input wire logic isWr,
  input wire logic isIo,
  input wire logic [7:0] cAddr,
  input wire logic [7:0] cData,
  output cpu_req_s cpuReq
);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpuReq <= '0;
    end else if (issue) begin
      cpuReq <= '{valid: 1'b1, write: isWr, ioInstr: isIo, addr: cAddr, wdata: cData};
    end else begin
      cpuReq <= '{valid: 1'b0, write: ~cpuReq.write, ioInstr: ~cpuReq.ioInstr, addr: ~cpuReq.addr,
                  wdata: ~cpuReq.wdata};
    end
  end
endmodule
`default_nettype wire

// ==== test/io_space_compat_tb_top.sv ====
// Purpose: Self-checking bench for the I/O space decode block.
// Assumes: Decode settles in the cycle a request is held; APB answers on pready.
// Notes: The clock can be held still to show that reset acts without it.
`timescale 1ns/100ps
`default_nettype none
module io_space_compat_tb_top
  import io_space_pkg::*;
;
  typedef struct packed {logic m; logic io; logic [7:0] a; target_e t; logic [4:0] d;} row_s;
  logic mclk, reset, extResetN, fuse, clkRun, psel, penable, pwrite, err, issue, isWr, isIo;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [7:0] cAddr, cData;
  cpu_req_s cpuReq;
  decode_s cpuDecode;
  target_e cpuTarget;
  feature_s features;
  logic [4:0] vectorCount;
  logic pready, pslverr;
  logic [PORT_PINS-1:0] padOut, padOeN, padPullUp;
  int miscompares, checkCount;
  // Decode bits are ext, short, ram, pin change, second timer.
  row_s rows [15] = '{'{0, 0, 8'h60, TGT_IO, 5'h10}, '{0, 0, 8'hff, TGT_IO, 5'h10},
    '{0, 0, 8'h6b, TGT_IO, 5'h12}, '{0, 0, 8'h8b, TGT_IO, 5'h11}, '{0, 1, 8'h3f, TGT_IO, 5'h08},
    '{0, 1, 8'h20, TGT_IO, 5'h08}, '{0, 0, 8'h5c, TGT_IO, 5'h08}, '{0, 1, 8'ha0, TGT_IO, 5'h08},
    '{1, 0, 8'h60, TGT_RAM, 5'h04}, '{1, 0, 8'hff, TGT_RAM, 5'h04}, '{1, 0, 8'h6b, TGT_RAM, 5'h04},
    '{1, 0, 8'h80, TGT_RAM, 5'h04}, '{1, 1, 8'h3c, TGT_IO, 5'h08}, '{1, 0, 8'h40, TGT_IO, 5'h08},
    '{1, 0, 8'h26, TGT_IO, 5'h08}};

  cpu_core_model cpu_core_model_inst (.mclk(mclk), .reset(reset), .issue(issue), .isWr(isWr),
    .isIo(isIo), .cAddr(cAddr), .cData(cData), .cpuReq(cpuReq));
  io_space_compat io_space_compat_inst (.mclk(mclk), .reset(reset), .extResetN(extResetN),
    .legacyCompatFuse(fuse), .cpuReq(cpuReq), .cpuDecode(cpuDecode), .cpuTarget(cpuTarget),
    .features(features), .vectorCount(vectorCount), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .padOut(padOut), .padOeN(padOeN), .padPullUp(padPullUp));

  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask

  task boot(input logic f);
    @(posedge mclk);
    reset <= 1'b1;
    fuse <= f;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task cpu(input logic io, input logic [7:0] a);
    @(posedge mclk);
    issue <= 1'b1;
    isIo <= io;
    isWr <= a[0];
    cAddr <= a;
    cData <= ~a;
    @(posedge mclk);
    issue <= 1'b0;
    @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = clkRun ? ~mclk : mclk;
  end

  initial begin
    #200000;
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    close_out;
  end

  initial begin
    {reset, extResetN, clkRun, fuse, psel, penable, pwrite, issue, isWr, isIo} = 10'b1110000000;
    {paddr, pwdata, cAddr, cData} = '0;
    miscompares = 0;
    checkCount = 0;
    boot(1'b0);
    foreach (rows[i]) begin
      if (rows[i].m !== fuse) begin
        boot(rows[i].m);
      end
      cpu(rows[i].io, rows[i].a);
      chk(64'(cpuTarget), 64'(rows[i].t), "target");
      chk(64'(cpuDecode), 64'(rows[i].d), "decode");
      chk(64'(features), 64'({5{~rows[i].m}}), "features");
      chk(64'(vectorCount), rows[i].m ? VEC_COUNT_LEGACY : VEC_COUNT_FULL, "vectors");
    end
    $display("test decode table done");
    apb(1'b0, APB_STATUS_OFS, 32'h0);
    chk(64'(rd & 32'h7d), 64'({5'(VEC_COUNT_LEGACY), 2'b01}), "legacy status");
    boot(1'b0);
    apb(1'b0, APB_STATUS_OFS, 32'h0);
    chk(64'(rd & 32'h7d), 64'({5'(VEC_COUNT_FULL), 2'b00}), "full status");
    apb(1'b0, APB_CTRL_OFS, 32'h0);
    chk(64'(rd), 64'(CTRL_RESET), "ctrl reset value");
    apb(1'b0, 12'h014, 32'h0);
    chk(64'({rd, err}), 64'h1, "unmapped read");
    $display("test registers done");
    apb(1'b1, APB_PULL_OFS, 32'ha5a53c3c);
    chk(64'(padPullUp[31:0]), 64'ha5a53c3c | (64'h1 << TDI_PIN) | (64'h1 << TMS_PIN)
        | (64'h1 << TCK_PIN), "pulls");
    apb(1'b1, APB_PORTE_OFS, 32'h00030405);
    chk(64'({padOeN[34:32], padPullUp[34:32], padOut[34], padOut[32]}), 64'h4a, "port e");
    apb(1'b0, APB_PORTE_OFS, 32'h0);
    chk(64'(rd), 64'h00030405, "port e readback");
    apb(1'b1, APB_PORTS_OFS, 32'h5a5affff);
    chk(64'({padOeN[31:16], padOut[31:16]}), 64'h5a5a, "ports c d");
    apb(1'b1, APB_CTRL_OFS, 32'h0);
    chk(64'(padPullUp[TDI_PIN]), 64'h0, "test pull off");
    $display("test pins done");
    // The clock is parked low so only the asynchronous path can float the pins.
    @(negedge mclk);
    clkRun = 1'b0;
    #30;
    extResetN = 1'b0;
    #5;
    chk(64'(padOeN), 64'({PORT_PINS{1'b1}}), "float in reset");
    chk(64'(padOut), 64'h0, "out in reset");
    chk(64'(padPullUp), (64'h1 << TDI_PIN) | (64'h1 << TMS_PIN) | (64'h1 << TCK_PIN), "test pulls");
    #200;
    extResetN = 1'b1;
    clkRun = 1'b1;
    repeat (3) @(posedge mclk);
    $display("test clockless reset done");
    close_out;
  end
endmodule
`default_nettype wire
